// ==== src/gig_ms_pkg.sv ====
// Constants and types for the gigabit master/slave management register slice
package gig_ms_pkg;
	localparam int DW = 16;
	localparam int AW = 5;
	localparam logic [4:0] ADDR_EXPANSION = 5'h06;
	localparam logic [4:0] ADDR_NP_RX = 5'h08;
	localparam logic [4:0] ADDR_MS_CTRL = 5'h09;
	localparam logic [4:0] ADDR_MS_STAT = 5'h0A;
	localparam logic [15:0] NP_RX_RESET = 16'h2000;
	localparam int EXP_PAGE_RX_BIT = 1;
	localparam int CTL_TM_HI = 15;
	localparam int CTL_TM_LO = 13;
	localparam int CTL_MAN_EN = 12;
	localparam int CTL_MAN_VAL = 11;
	localparam int CTL_PORT_TYPE = 10;
	localparam int CTL_ADV_FD = 9;
	localparam int CTL_ADV_HD = 8;
	localparam int ST_FAULT = 15;
	localparam int ST_RES = 14;
	localparam int ST_LRX = 13;
	localparam int ST_RRX = 12;
	localparam int ST_LP_FD = 11;
	localparam int ST_LP_HD = 10;
	localparam int ST_CNT_HI = 7;
	localparam int CNT_W = 8;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [2:0] TM_NORMAL = 3'h0;
	localparam logic [2:0] TM_WAVEFORM = 3'h1;
	localparam logic [2:0] TM_JIT_MASTER = 3'h2;
	localparam logic [2:0] TM_JIT_SLAVE = 3'h3;
	localparam logic [2:0] TM_DISTORT = 3'h4;
	typedef enum logic [2:0] {
		TMS_NORMAL, TMS_WAVEFORM, TMS_JIT_MASTER, TMS_JIT_SLAVE,
		TMS_DISTORT, TMS_RESERVED
	} test_mode_e;
	// Strap-selected defaults: {man_en, man_val, port_type, adv_fd, adv_hd}
	localparam logic [4:0] STRAP_MODE0 = 5'h00;
	localparam logic [4:0] STRAP_MODE1 = 5'h03;
	localparam logic [4:0] STRAP_MODE2 = 5'h07;
	localparam logic [4:0] STRAP_MODE3 = 5'h03;
endpackage : gig_ms_pkg

// ==== src/latch_high_bit.sv ====
// Latched-high status bit that clears on read once its cause is gone
`timescale 1ns/10ps
module latch_high_bit (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic sync_clr,
	// Event side
	input wire logic set_evt,
	input wire logic cond_live,
	input wire logic rd_clr,
	// State
	output logic flag
);
	logic flag_r;
	logic flag_nxt;
	// Set wins over a same-cycle read; a live cause keeps the bit up
	assign flag_nxt = set_evt | (flag_r & ~(rd_clr & ~cond_live));
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			flag_r <= 1'b0;
		end else if (sync_clr) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end
	assign flag = flag_r;

	AST_LH_SET: assert property (@(posedge clk_sys) disable iff (!rst_b)
		set_evt && !sync_clr |=> flag) else $error("latch bit lost set");
	AST_LH_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		flag && cond_live && !sync_clr |=> flag)
		else $error("latch bit cleared while cause live");
endmodule : latch_high_bit

// ==== src/idle_err_counter.sv ====
// Saturating idle-error counter with clear and overflow event
`timescale 1ns/10ps
module idle_err_counter (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Control
	input wire logic inc,
	input wire logic clr,
	// Results
	output logic [7:0] count,
	output logic overflow
);
	logic [7:0] count_r;
	logic [7:0] count_nxt;
	logic ovf_r;
	logic at_max;
	assign at_max = (count_r == gig_ms_pkg::CNT_MAX);
	// A clear in the cycle of an error still keeps that error
	assign count_nxt = clr ? (inc ? gig_ms_pkg::CNT_ONE
		: gig_ms_pkg::CNT_ZERO)
		: (inc && !at_max) ? count_r + gig_ms_pkg::CNT_ONE
		: count_r;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			count_r <= gig_ms_pkg::CNT_ZERO;
			ovf_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			ovf_r <= inc && at_max && !clr;
		end
	end
	assign count = count_r;
	assign overflow = ovf_r;

	AST_CNT_SAT: assert property (@(posedge clk_sys) disable iff (!rst_b)
		count_r == gig_ms_pkg::CNT_MAX && !clr |=> count_r == gig_ms_pkg::CNT_MAX)
		else $error("counter wrapped");
	AST_CNT_CLR: assert property (@(posedge clk_sys) disable iff (!rst_b)
		clr && !inc |=> count_r == gig_ms_pkg::CNT_ZERO)
		else $error("counter not cleared");
endmodule : idle_err_counter

// ==== src/gig_ms_regs.sv ====
// Next-page, master/slave control and master/slave status registers
`timescale 1ns/10ps
module gig_ms_regs (
	// Clock and resets
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic sw_reset,
	input wire logic logic_reset,
	// Mode strap pins
	input wire logic [1:0] mode_strap,
	// Management register port
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// From negotiation and line logic
	input wire logic np_rx_valid,
	input wire logic [15:0] np_rx_word,
	input wire logic page_rx_evt,
	input wire logic ms_fault,
	input wire logic ms_resolved_master,
	input wire logic local_rx_ok,
	input wire logic remote_rx_ok,
	input wire logic partner_gig_full_ability,
	input wire logic partner_gig_half_ability,
	input wire logic idle_err,
	// To negotiation and line logic
	output logic [4:0] test_mode_sel,
	output logic role_force,
	output logic role_force_master,
	output logic port_multi,
	output logic adv_gig_full,
	output logic adv_gig_half,
	output logic page_received,
	output logic idle_err_overflow
);
	logic [1:0] strap_s1_r;
	logic [1:0] strap_s2_r;
	logic strap_load_r;
	logic [15:0] np_rx_r;
	logic [2:0] tm_r;
	logic man_en_r;
	logic man_val_r;
	logic port_type_r;
	logic adv_fd_r;
	logic adv_hd_r;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic [15:0] ctrl_word;
	logic [15:0] stat_word;
	logic [15:0] exp_word;
	logic [4:0] strap_val;
	logic [7:0] err_count;
	logic fault_flag;
	logic wr_ctrl;
	logic rd_stat;
	logic rd_exp;
	logic cnt_clr;
	gig_ms_pkg::test_mode_e tm_kind;

	function automatic gig_ms_pkg::test_mode_e decode_tm(
		input logic [2:0] code);
		gig_ms_pkg::test_mode_e k;
		unique case (code)
			gig_ms_pkg::TM_NORMAL: k = gig_ms_pkg::TMS_NORMAL;
			gig_ms_pkg::TM_WAVEFORM: k = gig_ms_pkg::TMS_WAVEFORM;
			gig_ms_pkg::TM_JIT_MASTER: k = gig_ms_pkg::TMS_JIT_MASTER;
			gig_ms_pkg::TM_JIT_SLAVE: k = gig_ms_pkg::TMS_JIT_SLAVE;
			gig_ms_pkg::TM_DISTORT: k = gig_ms_pkg::TMS_DISTORT;
			default: k = gig_ms_pkg::TMS_RESERVED;
		endcase
		return k;
	endfunction : decode_tm

	function automatic logic [4:0] strap_table(input logic [1:0] m);
		logic [4:0] v;
		unique case (m)
			2'h0: v = gig_ms_pkg::STRAP_MODE0;
			2'h1: v = gig_ms_pkg::STRAP_MODE1;
			2'h2: v = gig_ms_pkg::STRAP_MODE2;
			2'h3: v = gig_ms_pkg::STRAP_MODE3;
		endcase
		return v;
	endfunction : strap_table

	// Address decode
	assign wr_ctrl = reg_wr && (reg_addr == gig_ms_pkg::ADDR_MS_CTRL);
	assign rd_stat = reg_rd && (reg_addr == gig_ms_pkg::ADDR_MS_STAT);
	assign rd_exp = reg_rd && (reg_addr == gig_ms_pkg::ADDR_EXPANSION);
	assign cnt_clr = rd_stat || sw_reset || logic_reset;
	assign strap_val = strap_table(strap_s2_r);

	// Straps are pins: synchronise, then load after reset release
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			strap_s1_r <= 2'h0;
			strap_s2_r <= 2'h0;
		end else begin
			strap_s1_r <= mode_strap;
			strap_s2_r <= strap_s1_r;
		end
	end
	// Load waits two edges so the synchroniser holds the strap level
	logic [1:0] load_cnt_r;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			load_cnt_r <= 2'h0;
		end else if (load_cnt_r != 2'h3) begin
			load_cnt_r <= load_cnt_r + 2'h1;
		end
	end
	assign strap_load_r = (load_cnt_r == 2'h2);

	// Partner next page
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			np_rx_r <= gig_ms_pkg::NP_RX_RESET;
		end else if (sw_reset) begin
			np_rx_r <= gig_ms_pkg::NP_RX_RESET;
		end else if (np_rx_valid) begin
			np_rx_r <= np_rx_word;
		end
	end

	// Control register: straps at reset, then software
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tm_r <= gig_ms_pkg::TM_NORMAL;
			{man_en_r, man_val_r, port_type_r, adv_fd_r, adv_hd_r} <= 5'h00;
		end else if (strap_load_r || sw_reset) begin
			tm_r <= gig_ms_pkg::TM_NORMAL;
			{man_en_r, man_val_r, port_type_r, adv_fd_r, adv_hd_r}
				<= strap_val;
		end else if (wr_ctrl) begin
			// Bits 7:0 are reserved, so their write data is dropped
			tm_r <= reg_wdata[gig_ms_pkg::CTL_TM_HI:gig_ms_pkg::CTL_TM_LO];
			man_en_r <= reg_wdata[gig_ms_pkg::CTL_MAN_EN];
			man_val_r <= reg_wdata[gig_ms_pkg::CTL_MAN_VAL];
			port_type_r <= reg_wdata[gig_ms_pkg::CTL_PORT_TYPE];
			adv_fd_r <= reg_wdata[gig_ms_pkg::CTL_ADV_FD];
			adv_hd_r <= reg_wdata[gig_ms_pkg::CTL_ADV_HD];
		end
	end

	// Control outputs to the line side
	assign tm_kind = decode_tm(tm_r);
	assign test_mode_sel = {tm_kind == gig_ms_pkg::TMS_DISTORT,
		tm_kind == gig_ms_pkg::TMS_JIT_SLAVE,
		tm_kind == gig_ms_pkg::TMS_JIT_MASTER,
		tm_kind == gig_ms_pkg::TMS_WAVEFORM,
		tm_kind == gig_ms_pkg::TMS_NORMAL};
	// Both ends master is software's problem; no interlock here
	assign role_force = man_en_r;
	assign role_force_master = man_en_r & man_val_r;
	assign port_multi = ~man_en_r & port_type_r;
	assign adv_gig_full = adv_fd_r;
	assign adv_gig_half = adv_hd_r;

	// Latched fault and page-received flags
	latch_high_bit u_fault (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.sync_clr(sw_reset),
		.set_evt(ms_fault),
		.cond_live(ms_fault),
		.rd_clr(rd_stat),
		.flag(fault_flag)
	);
	latch_high_bit u_page (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.sync_clr(sw_reset),
		.set_evt(page_rx_evt),
		.cond_live(1'b0),
		.rd_clr(rd_exp),
		.flag(page_received)
	);

	idle_err_counter u_cnt (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.inc(idle_err),
		.clr(cnt_clr),
		.count(err_count),
		.overflow(idle_err_overflow)
	);

	// Read words; reserved bits are zero
	assign ctrl_word = {tm_r, man_en_r, man_val_r, port_type_r,
		adv_fd_r, adv_hd_r, 8'h00};
	assign stat_word = {fault_flag, ms_resolved_master, local_rx_ok,
		remote_rx_ok, partner_gig_full_ability, partner_gig_half_ability,
		2'h0, err_count};
	assign exp_word = {14'h0000, page_received, 1'b0};
	assign rdata_nxt = (reg_addr == gig_ms_pkg::ADDR_NP_RX) ? np_rx_r
		: (reg_addr == gig_ms_pkg::ADDR_MS_CTRL) ? ctrl_word
		: (reg_addr == gig_ms_pkg::ADDR_MS_STAT) ? stat_word
		: (reg_addr == gig_ms_pkg::ADDR_EXPANSION) ? exp_word
		: 16'h0000;

	// Data captured with the read; clear-on-read acts after capture
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			rdata_r <= rdata_nxt;
		end
	end
	assign reg_rdata = rdata_r;

	AST_NP_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		np_rx_valid && !sw_reset |=> np_rx_r == $past(np_rx_word))
		else $error("next page not captured");
	AST_TM_DEC: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$onehot0(test_mode_sel) && ((tm_r > gig_ms_pkg::TM_DISTORT)
		== (test_mode_sel == 5'h00))) else $error("test mode decode bad");
	AST_ROLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!man_en_r |-> !role_force_master) else $error("role forced");
	AST_PORT: assert property (@(posedge clk_sys) disable iff (!rst_b)
		man_en_r |-> !port_multi) else $error("port type leaks");
	AST_ADV_WR: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_ctrl && !strap_load_r && !sw_reset |=> adv_gig_full
		== $past(reg_wdata[gig_ms_pkg::CTL_ADV_FD]))
		else $error("advert write lost");
	AST_STRAP: assert property (@(posedge clk_sys) disable iff (!rst_b)
		strap_load_r |=> {man_en_r, man_val_r, port_type_r, adv_fd_r,
		adv_hd_r} == $past(strap_val)) else $error("strap not loaded");
	AST_FAULT_RD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_stat && fault_flag |=> rdata_r[gig_ms_pkg::ST_FAULT])
		else $error("fault not reported");
	AST_STAT_RD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_stat |=> rdata_r[gig_ms_pkg::ST_RES] == $past(ms_resolved_master)
		&& rdata_r[gig_ms_pkg::ST_LRX] == $past(local_rx_ok))
		else $error("status read wrong");
	AST_LP_RD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_stat |=> rdata_r[gig_ms_pkg::ST_LP_FD]
		== $past(partner_gig_full_ability)) else $error("lp ability");
	AST_RD_CLR: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_stat && !idle_err |=> err_count == gig_ms_pkg::CNT_ZERO)
		else $error("count not cleared on read");
	AST_OVF: assert property (@(posedge clk_sys) disable iff (!rst_b)
		idle_err && err_count == gig_ms_pkg::CNT_MAX && !cnt_clr
		|=> idle_err_overflow) else $error("no overflow event");
	AST_RSVD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		reg_rd |=> rdata_r[9:8] == 2'h0 || $past(reg_addr)
		== gig_ms_pkg::ADDR_NP_RX || $past(reg_addr)
		== gig_ms_pkg::ADDR_MS_CTRL) else $error("reserved bits set");
	AST_PAGE: assert property (@(posedge clk_sys) disable iff (!rst_b)
		page_rx_evt && !sw_reset |=> page_received)
		else $error("page flag lost");
	AST_NP_RST: assert property (@(posedge clk_sys) disable iff (!rst_b)
		sw_reset |=> np_rx_r == gig_ms_pkg::NP_RX_RESET)
		else $error("next page reset value");
	AST_RRX_RD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_stat |=> rdata_r[gig_ms_pkg::ST_RRX] == $past(remote_rx_ok))
		else $error("remote status wrong");
	AST_LP_HD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_stat |=> rdata_r[gig_ms_pkg::ST_LP_HD]
		== $past(partner_gig_half_ability)) else $error("lp half");
	AST_CNT_INC: assert property (@(posedge clk_sys) disable iff (!rst_b)
		idle_err && !cnt_clr && err_count != gig_ms_pkg::CNT_MAX
		|=> err_count == $past(err_count) + gig_ms_pkg::CNT_ONE)
		else $error("error not counted");
	AST_CNT_LRST: assert property (@(posedge clk_sys) disable iff (!rst_b)
		logic_reset && !idle_err |=> err_count == gig_ms_pkg::CNT_ZERO)
		else $error("logic reset kept count");
	AST_ROLE_WR: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_ctrl && !strap_load_r && !sw_reset |=> role_force_master
		== $past(reg_wdata[gig_ms_pkg::CTL_MAN_EN]
		& reg_wdata[gig_ms_pkg::CTL_MAN_VAL]))
		else $error("role force wrong");
	AST_PORT_FREE: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!man_en_r |-> port_multi == port_type_r)
		else $error("port type ignored");
	AST_CTRL_LOW: assert property (@(posedge clk_sys) disable iff (!rst_b)
		reg_rd && reg_addr == gig_ms_pkg::ADDR_MS_CTRL
		|=> rdata_r[gig_ms_pkg::ST_CNT_HI:0] == 8'h00)
		else $error("control low byte set");
	AST_EXP_RD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_exp |=> rdata_r[gig_ms_pkg::EXP_PAGE_RX_BIT]
		== $past(page_received)) else $error("page flag read");
	AST_PAGE_CLR: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_exp && !page_rx_evt && !sw_reset |=> !page_received)
		else $error("page flag kept");
	AST_FAULT_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_stat && ms_fault && !sw_reset |=> fault_flag)
		else $error("live fault cleared");
	AST_TM_SWRST: assert property (@(posedge clk_sys) disable iff (!rst_b)
		sw_reset |=> test_mode_sel == 5'h01)
		else $error("test mode not reset");
	CV_PAGE_RD: cover property (@(posedge clk_sys) disable iff (!rst_b)
		page_received && rd_exp);
	CV_FAULT_RD: cover property (@(posedge clk_sys) disable iff (!rst_b)
		fault_flag && rd_stat && !ms_fault);
	CV_SAT: cover property (@(posedge clk_sys) disable iff (!rst_b)
		idle_err_overflow);
	CV_MANUAL: cover property (@(posedge clk_sys) disable iff (!rst_b)
		role_force_master);
	CV_TEST: cover property (@(posedge clk_sys) disable iff (!rst_b)
		test_mode_sel[4]);
endmodule : gig_ms_regs

// ==== tb/gig_line_model.sv ====
// Behavioural negotiation and line-side source for the register slice
`timescale 1ns/10ps
module gig_line_model (
	// Clock
	input wire logic clk_sys,
	// Negotiation side
	output logic np_rx_valid,
	output logic [15:0] np_rx_word,
	output logic page_rx_evt,
	// Line status: {resolved master, local ok, remote ok, fd, hd}
	output logic ms_fault,
	output logic [4:0] line_st,
	output logic idle_err
);
	initial begin
		np_rx_valid = 1'b0;
		np_rx_word = 16'h0000;
		page_rx_evt = 1'b0;
		ms_fault = 1'b0;
		line_st = 5'h00;
		idle_err = 1'b0;
	end
	// Word is not held after its strobe, so a late sample shows garbage
	task send_page(input logic [15:0] w);
		@(posedge clk_sys) #1;
		np_rx_valid = 1'b1;
		page_rx_evt = 1'b1;
		np_rx_word = w;
		@(posedge clk_sys) #1;
		np_rx_valid = 1'b0;
		page_rx_evt = 1'b0;
		np_rx_word = ~w;
	endtask : send_page
	task set_line(input logic f, input logic [4:0] s);
		@(posedge clk_sys) #1;
		ms_fault = f;
		line_st = s;
	endtask : set_line
	// Back-to-back errors, one per cycle
	task idle_errs(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys) #1;
			idle_err = 1'b1;
		end
		@(posedge clk_sys) #1;
		idle_err = 1'b0;
	endtask : idle_errs
endmodule : gig_line_model

// ==== tb/gig_ms_regs_bench.sv ====
// Self-checking bench for the master/slave management register slice
`timescale 1ns/10ps
module gig_ms_regs_bench;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic sw_reset = 1'b0;
	logic logic_reset = 1'b0;
	logic [1:0] mode_strap = 2'h1;
	logic [4:0] reg_addr = 5'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata, np_rx_word, w, d, g;
	logic np_rx_valid, page_rx_evt, ms_fault, idle_err;
	logic [4:0] line_st, test_mode_sel, e5;
	logic [4:0] st_tab [4];
	logic role_force, role_force_master, port_multi;
	logic adv_gig_full, adv_gig_half, page_received, idle_err_overflow;
	logic [15:0] rnd = 16'h0EC0;
	int error_cnt = 0;
	int samples_checked = 0;
	int ovf_n = 0;
	always #2 clk_sys = ~clk_sys;
	gig_ms_regs u_gig_ms_regs (.clk_sys(clk_sys), .rst_b(rst_b),
		.sw_reset(sw_reset), .logic_reset(logic_reset),
		.mode_strap(mode_strap), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.np_rx_valid(np_rx_valid), .np_rx_word(np_rx_word),
		.page_rx_evt(page_rx_evt), .ms_fault(ms_fault),
		.ms_resolved_master(line_st[4]), .local_rx_ok(line_st[3]),
		.remote_rx_ok(line_st[2]), .partner_gig_full_ability(line_st[1]),
		.partner_gig_half_ability(line_st[0]), .idle_err(idle_err),
		.test_mode_sel(test_mode_sel), .role_force(role_force),
		.role_force_master(role_force_master), .port_multi(port_multi),
		.adv_gig_full(adv_gig_full), .adv_gig_half(adv_gig_half),
		.page_received(page_received),
		.idle_err_overflow(idle_err_overflow));
	gig_line_model u_gig_line_model (.clk_sys(clk_sys),
		.np_rx_valid(np_rx_valid), .np_rx_word(np_rx_word),
		.page_rx_evt(page_rx_evt), .ms_fault(ms_fault), .line_st(line_st),
		.idle_err(idle_err));
	// Sampled mid-cycle, away from the edge that launches the pulse
	always @(negedge clk_sys) begin
		if (idle_err_overflow === 1'b1) begin
			ovf_n++;
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge clk_sys) #1;
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge clk_sys) #1;
		reg_wr = 1'b0;
	endtask : wr
	task rdc(input logic [4:0] a, input logic [15:0] e, input string n);
		@(posedge clk_sys) #1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk_sys) #1;
		reg_rd = 1'b0;
		chk(n, e, reg_rdata);
	endtask : rdc
	// Live levels are taken from the line model, not from the design
	task stat(input logic f, input logic [7:0] c);
		rdc(gig_ms_pkg::ADDR_MS_STAT, {f, line_st, 2'b00, c}, "status");
	endtask : stat
	task pulse_sw;
		@(posedge clk_sys) #1;
		sw_reset = 1'b1;
		@(posedge clk_sys) #1;
		sw_reset = 1'b0;
	endtask : pulse_sw
	task finish_test;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	initial begin
		#80000;
		error_cnt++;
		$display("[ERR] watchdog expected done seen hang");
		finish_test;
	end
	initial begin
		st_tab = '{gig_ms_pkg::STRAP_MODE0, gig_ms_pkg::STRAP_MODE1,
			gig_ms_pkg::STRAP_MODE2, gig_ms_pkg::STRAP_MODE3};
		repeat (10) @(posedge clk_sys);
		#1 rst_b = 1'b1;
		repeat (4) @(posedge clk_sys);
		rdc(gig_ms_pkg::ADDR_NP_RX, gig_ms_pkg::NP_RX_RESET,
			"np");
		rdc(gig_ms_pkg::ADDR_MS_CTRL, {3'h0, st_tab[1], 8'h00},
			"ctl");
		stat(1'b0, 8'h00);
		for (int tm = 0; tm < 8; tm++) begin
			rnd = lfsr(rnd);
			w = {tm[2:0], rnd[12:0]};
			// Never force master while the master jitter test runs
			if (tm == 2) w[11] = 1'b0;
			e5 = (tm < 5) ? 5'h01 << tm : 5'h00;
			wr(gig_ms_pkg::ADDR_MS_CTRL, w);
			d = {6'h00, e5, w[12], w[12] & w[11], ~w[12] & w[10],
				w[9], w[8]};
			g = {6'h00, test_mode_sel, role_force, role_force_master,
				port_multi, adv_gig_full, adv_gig_half};
			chk("ctl out", d, g);
			rdc(gig_ms_pkg::ADDR_MS_CTRL, w & 16'hFF00,
				"ctl rd");
		end
		wr(gig_ms_pkg::ADDR_NP_RX, 16'hFFFF);
		rdc(gig_ms_pkg::ADDR_NP_RX, gig_ms_pkg::NP_RX_RESET,
			"np");
		wr(gig_ms_pkg::ADDR_MS_STAT, 16'hFFFF);
		stat(1'b0, 8'h00);
		rdc(5'h1F, 16'h0000, "unmapped");
		rnd = lfsr(rnd);
		u_gig_line_model.send_page(rnd);
		chk("page flag", 16'h0001, {15'h0000, page_received});
		rdc(gig_ms_pkg::ADDR_NP_RX, rnd, "np");
		rdc(gig_ms_pkg::ADDR_EXPANSION, 16'h0002, "exp");
		rdc(gig_ms_pkg::ADDR_EXPANSION, 16'h0000, "exp");
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			u_gig_line_model.set_line(1'b0, rnd[4:0]);
			stat(1'b0, 8'h00);
		end
		u_gig_line_model.set_line(1'b1, line_st);
		u_gig_line_model.set_line(1'b0, line_st);
		stat(1'b1, 8'h00);
		stat(1'b0, 8'h00);
		u_gig_line_model.set_line(1'b1, line_st);
		stat(1'b1, 8'h00);
		stat(1'b1, 8'h00);
		u_gig_line_model.set_line(1'b0, line_st);
		stat(1'b1, 8'h00);
		stat(1'b0, 8'h00);
		u_gig_line_model.idle_errs(5);
		stat(1'b0, 8'h05);
		stat(1'b0, 8'h00);
		// 255 errors fill the count, the remaining 45 each overflow
		u_gig_line_model.idle_errs(300);
		stat(1'b0, 8'hFF);
		chk("overflows", 16'h002D, ovf_n[15:0]);
		stat(1'b0, 8'h00);
		u_gig_line_model.idle_errs(3);
		@(posedge clk_sys) #1;
		logic_reset = 1'b1;
		@(posedge clk_sys) #1;
		logic_reset = 1'b0;
		stat(1'b0, 8'h00);
		// Hardware reset in mid-run clears the count and reloads straps
		u_gig_line_model.idle_errs(3);
		@(posedge clk_sys) #1;
		rst_b = 1'b0;
		@(posedge clk_sys) #1;
		rst_b = 1'b1;
		repeat (4) @(posedge clk_sys);
		stat(1'b0, 8'h00);
		rdc(gig_ms_pkg::ADDR_MS_CTRL, {3'h0, st_tab[1], 8'h00},
			"ctl");
		for (int m = 0; m < 4; m++) begin
			wr(gig_ms_pkg::ADDR_MS_CTRL, 16'hFFFF);
			u_gig_line_model.send_page(16'hFFFF);
			u_gig_line_model.idle_errs(2);
			mode_strap = m[1:0];
			repeat (3) @(posedge clk_sys);
			pulse_sw;
			chk("tm sel", 16'h0001, {11'h000, test_mode_sel});
			rdc(gig_ms_pkg::ADDR_MS_CTRL, {3'h0, st_tab[m], 8'h00},
				"ctl");
			stat(1'b0, 8'h00);
			rdc(gig_ms_pkg::ADDR_NP_RX, gig_ms_pkg::NP_RX_RESET,
				"np");
			rdc(gig_ms_pkg::ADDR_EXPANSION, 16'h0000, "exp");
		end
		finish_test;
	end
endmodule : gig_ms_regs_bench
